// *** shared/ptirq_pkg.sv ***
// Package for the pressure/temperature event interrupt block
package ptirq_pkg;
  // Register indices (byte addresses on the internal register port)
  localparam logic [3:0] ADDR_PA_UP_LO = 4'h2;
  localparam logic [3:0] ADDR_PA_UP_HI = 4'h3;
  localparam logic [3:0] ADDR_PA_MID_LO = 4'h4;
  localparam logic [3:0] ADDR_PA_MID_HI = 4'h5;
  localparam logic [3:0] ADDR_PA_LOW_LO = 4'h6;
  localparam logic [3:0] ADDR_PA_LOW_HI = 4'h7;
  localparam logic [3:0] ADDR_T_UP = 4'h8;
  localparam logic [3:0] ADDR_T_MID = 4'h9;
  localparam logic [3:0] ADDR_T_LOW = 4'hA;
  localparam logic [3:0] ADDR_EVT_EN = 4'hB;
  localparam logic [3:0] ADDR_EVT_ROUTE = 4'hC;
  localparam logic [3:0] ADDR_EVT_FLAGS = 4'hD;
  localparam logic [3:0] ADDR_EVT_DIR = 4'hE;
  localparam logic [3:0] ADDR_COMP_CTRL = 4'hF;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_COMP_CTRL = 8'h80;
  // Event bit positions (enable, routing and flag registers)
  localparam int BIT_TEMP_OUTSIDE_EVENT = 0;
  localparam int BIT_PRESS_ALT_OUTSIDE_EVENT = 1;
  localparam int BIT_TEMP_CROSS_EVENT = 2;
  localparam int BIT_PRESS_ALT_CROSS_EVENT = 3;
  localparam int BIT_T_RDY = 4;
  localparam int BIT_PRESS_ALT_DONE_EVENT = 5;
  localparam int BIT_MODE = 6;
  localparam int BIT_IDLE = 6;
  localparam int BIT_ERR = 7;
  localparam int BIT_COMP = 7;
  // Direction bit positions
  localparam int DIR_TEMP_OUTSIDE_EVENT = 0;
  localparam int DIR_P_WIN = 1;
  localparam int DIR_TEMP_CROSS_EVENT = 2;
  localparam int DIR_P_TRAV = 3;

  // Host commands as decoded by the command front end
  typedef enum logic [2:0] {
    PTIRQ_CMD_CONVERT = 3'h0,
    PTIRQ_CMD_READ_PRESS_TEMP_COMMAND = 3'h1,
    PTIRQ_CMD_READ_ALT_TEMP_COMMAND = 3'h2,
    PTIRQ_CMD_READ_P = 3'h3,
    PTIRQ_CMD_READ_A = 3'h4,
    PTIRQ_CMD_READ_T = 3'h5,
    PTIRQ_CMD_SOFT_RST = 3'h6
  } ptirq_cmd_e;

  // Register port request
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ptirq_reg_req_s;

  // One finished conversion result
  typedef struct packed {
    logic valid;
    logic signed [23:0] value;
  } ptirq_meas_s;
endpackage

// *** src/ptirq_core.sv ***
// Event detection, flags and interrupt pin for the pressure/temp sensor
`timescale 1ns/1ps
module ptirq_core
  import ptirq_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic i_reg_en,
  input wire ptirq_reg_req_s i_reg_req,
  output logic [7:0] o_reg_rdata,
  // Commands, valid for one cycle once recognised
  input wire logic i_cmd_valid,
  input wire ptirq_cmd_e i_cmd,
  // Conversion results and device state
  input wire ptirq_meas_s i_temp_meas,
  input wire ptirq_meas_s i_pa_meas,
  input wire logic i_dev_busy,
  // Outputs
  output logic o_event_pin,
  output logic o_compensation_enable,
  output logic o_channel_altitude_select
);

  logic [7:0] pa_up_lo, pa_up_hi, pa_mid_lo, pa_mid_hi, pa_low_lo, pa_low_hi;
  logic [7:0] t_up, t_mid, t_low, evt_en, evt_route, comp_ctrl;
  logic [5:0] flags;
  logic [3:0] dir;
  logic t_rdy, press_alt_done_event;
  logic signed [23:0] t_prev, pa_prev;
  logic t_prev_ok, pa_prev_ok;

  // Register write decode
  wire wr = i_reg_en && i_reg_req.wr;
  wire soft_rst = i_cmd_valid && (i_cmd == PTIRQ_CMD_SOFT_RST);

  wire alt_mode = evt_route[BIT_MODE];
  wire [15:0] pa_up = {pa_up_hi, pa_up_lo};
  wire [15:0] pa_mid = {pa_mid_hi, pa_mid_lo};
  wire [15:0] pa_low = {pa_low_hi, pa_low_lo};
  wire signed [24:0] pa_up_x = alt_mode ? 25'(signed'(pa_up))
                                        : 25'(signed'({1'b0, pa_up}));
  wire signed [24:0] pa_mid_x = alt_mode ? 25'(signed'(pa_mid))
                                         : 25'(signed'({1'b0, pa_mid}));
  wire signed [24:0] pa_low_x = alt_mode ? 25'(signed'(pa_low))
                                         : 25'(signed'({1'b0, pa_low}));
  wire signed [24:0] t_up_x = 25'(signed'(t_up));
  wire signed [24:0] t_mid_x = 25'(signed'(t_mid));
  wire signed [24:0] t_low_x = 25'(signed'(t_low));
  wire signed [24:0] pa_val = 25'(i_pa_meas.value);
  wire signed [24:0] t_val = 25'(i_temp_meas.value);
  wire signed [24:0] pa_old = 25'(pa_prev);
  wire signed [24:0] t_old = 25'(t_prev);

  wire limit_err = (pa_low_x > pa_up_x) || (pa_mid_x > pa_up_x) ||
                   (pa_low_x > pa_mid_x) || (t_low_x > t_up_x) ||
                   (t_mid_x > t_up_x) || (t_low_x > t_mid_x);

  wire t_above = t_val > t_up_x;
  wire t_below = t_val < t_low_x;
  wire pa_above = pa_val > pa_up_x;
  wire pa_below = pa_val < pa_low_x;
  // crossing uses previous and current sample
  wire t_rise = t_prev_ok && (t_old < t_mid_x) && (t_val >= t_mid_x);
  wire t_fall = t_prev_ok && (t_old >= t_mid_x) && (t_val < t_mid_x);
  wire pa_rise = pa_prev_ok && (pa_old < pa_mid_x) && (pa_val >= pa_mid_x);
  wire pa_fall = pa_prev_ok && (pa_old >= pa_mid_x) && (pa_val < pa_mid_x);

  wire clr_t = i_cmd_valid && (i_cmd == PTIRQ_CMD_CONVERT ||
               i_cmd == PTIRQ_CMD_READ_PRESS_TEMP_COMMAND || i_cmd == PTIRQ_CMD_READ_ALT_TEMP_COMMAND ||
               i_cmd == PTIRQ_CMD_READ_T);
  wire clr_pa = i_cmd_valid && (i_cmd == PTIRQ_CMD_CONVERT ||
                i_cmd == PTIRQ_CMD_READ_PRESS_TEMP_COMMAND || i_cmd == PTIRQ_CMD_READ_ALT_TEMP_COMMAND ||
                i_cmd == PTIRQ_CMD_READ_P || i_cmd == PTIRQ_CMD_READ_A);
  wire t_done = i_temp_meas.valid && evt_en[BIT_T_RDY];
  wire pa_done = i_pa_meas.valid && evt_en[BIT_PRESS_ALT_DONE_EVENT];

  // Threshold and control registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pa_up_lo <= RST_ZERO;
      pa_up_hi <= RST_ZERO;
      pa_mid_lo <= RST_ZERO;
      pa_mid_hi <= RST_ZERO;
      pa_low_lo <= RST_ZERO;
      pa_low_hi <= RST_ZERO;
      t_up <= RST_ZERO;
      t_mid <= RST_ZERO;
      t_low <= RST_ZERO;
      evt_en <= RST_ZERO;
      evt_route <= RST_ZERO;
      comp_ctrl <= RST_COMP_CTRL;
    end
    else if (wr)
    begin
      unique case (i_reg_req.addr)
        ADDR_PA_UP_LO: pa_up_lo <= i_reg_req.wdata;
        ADDR_PA_UP_HI: pa_up_hi <= i_reg_req.wdata;
        ADDR_PA_MID_LO: pa_mid_lo <= i_reg_req.wdata;
        ADDR_PA_MID_HI: pa_mid_hi <= i_reg_req.wdata;
        ADDR_PA_LOW_LO: pa_low_lo <= i_reg_req.wdata;
        ADDR_PA_LOW_HI: pa_low_hi <= i_reg_req.wdata;
        ADDR_T_UP: t_up <= i_reg_req.wdata;
        ADDR_T_MID: t_mid <= i_reg_req.wdata;
        ADDR_T_LOW: t_low <= i_reg_req.wdata;
        ADDR_EVT_EN: evt_en <= {2'b00, i_reg_req.wdata[5:0]};
        ADDR_EVT_ROUTE: evt_route <= {1'b0, i_reg_req.wdata[6:0]};
        ADDR_COMP_CTRL: comp_ctrl <= {i_reg_req.wdata[BIT_COMP], 7'h00};
        default: ;
      endcase
    end
  end

  // Event state: done events, sticky flags, directions, last samples
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      t_rdy <= 1'b0;
      press_alt_done_event <= 1'b0;
      flags <= 6'h00;
      dir <= 4'h0;
      t_prev <= 24'h000000;
      pa_prev <= 24'h000000;
      t_prev_ok <= 1'b0;
      pa_prev_ok <= 1'b0;
    end
    else if (soft_rst)
    begin
      t_rdy <= 1'b0;
      press_alt_done_event <= 1'b0;
      flags <= 6'h00;
      dir <= 4'h0;
      t_prev_ok <= 1'b0;
      pa_prev_ok <= 1'b0;
    end
    else
    begin
      // completion wins over a clear in the same cycle
      if (t_done)
        t_rdy <= 1'b1;
      else if (clr_t)
        t_rdy <= 1'b0;
      if (pa_done)
        press_alt_done_event <= 1'b1;
      else if (clr_pa)
        press_alt_done_event <= 1'b0;
      if (i_temp_meas.valid)
      begin
        t_prev <= i_temp_meas.value;
        t_prev_ok <= 1'b1;
        // flags updated on every sample; events set only with done enabled
        // Ready flag tracks t_rdy so a disabled conversion cannot hide it
        flags[BIT_T_RDY] <= t_done || (t_rdy && !clr_t);
        flags[BIT_TEMP_OUTSIDE_EVENT] <= t_done && evt_en[BIT_TEMP_OUTSIDE_EVENT] &&
                            (t_above || t_below);
        flags[BIT_TEMP_CROSS_EVENT] <= t_done && evt_en[BIT_TEMP_CROSS_EVENT] &&
                             (t_rise || t_fall);
        dir[DIR_TEMP_OUTSIDE_EVENT] <= t_above;
        dir[DIR_TEMP_CROSS_EVENT] <= t_rise;
      end
      else if (clr_t)
        flags[BIT_T_RDY] <= 1'b0;
      if (i_pa_meas.valid)
      begin
        pa_prev <= i_pa_meas.value;
        pa_prev_ok <= 1'b1;
        flags[BIT_PRESS_ALT_DONE_EVENT] <= pa_done || (press_alt_done_event && !clr_pa);
        flags[BIT_PRESS_ALT_OUTSIDE_EVENT] <= pa_done && evt_en[BIT_PRESS_ALT_OUTSIDE_EVENT] &&
                             (pa_above || pa_below);
        flags[BIT_PRESS_ALT_CROSS_EVENT] <= pa_done && evt_en[BIT_PRESS_ALT_CROSS_EVENT] &&
                              (pa_rise || pa_fall);
        dir[DIR_P_WIN] <= pa_above;
        dir[DIR_P_TRAV] <= pa_rise;
      end
      else if (clr_pa)
        flags[BIT_PRESS_ALT_DONE_EVENT] <= 1'b0;
    end
  end

  // live cross/outside events drop with their done event
  wire [5:0] live;
  assign live[BIT_T_RDY] = t_rdy;
  assign live[BIT_PRESS_ALT_DONE_EVENT] = press_alt_done_event;
  assign live[BIT_TEMP_OUTSIDE_EVENT] = t_rdy && flags[BIT_TEMP_OUTSIDE_EVENT];
  assign live[BIT_TEMP_CROSS_EVENT] = t_rdy && flags[BIT_TEMP_CROSS_EVENT];
  assign live[BIT_PRESS_ALT_OUTSIDE_EVENT] = press_alt_done_event && flags[BIT_PRESS_ALT_OUTSIDE_EVENT];
  assign live[BIT_PRESS_ALT_CROSS_EVENT] = press_alt_done_event && flags[BIT_PRESS_ALT_CROSS_EVENT];

  // pin from routed live events only
  wire next_pin = |(live & evt_route[5:0]);
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_event_pin <= 1'b0;
    else
      o_event_pin <= next_pin;
  end

  wire idle = !i_dev_busy;
  assign o_compensation_enable = comp_ctrl[BIT_COMP];
  assign o_channel_altitude_select = alt_mode;

  // Read mux; unmapped addresses read zero
  wire [7:0] flag_rd = {limit_err, idle, flags};
  wire [7:0] dir_rd = {comp_ctrl[BIT_COMP], 3'b000, dir};
  always_comb
  begin
    unique case (i_reg_req.addr)
      ADDR_PA_UP_LO: o_reg_rdata = pa_up_lo;
      ADDR_PA_UP_HI: o_reg_rdata = pa_up_hi;
      ADDR_PA_MID_LO: o_reg_rdata = pa_mid_lo;
      ADDR_PA_MID_HI: o_reg_rdata = pa_mid_hi;
      ADDR_PA_LOW_LO: o_reg_rdata = pa_low_lo;
      ADDR_PA_LOW_HI: o_reg_rdata = pa_low_hi;
      ADDR_T_UP: o_reg_rdata = t_up;
      ADDR_T_MID: o_reg_rdata = t_mid;
      ADDR_T_LOW: o_reg_rdata = t_low;
      ADDR_EVT_EN: o_reg_rdata = evt_en;
      ADDR_EVT_ROUTE: o_reg_rdata = evt_route;
      ADDR_EVT_FLAGS: o_reg_rdata = flag_rd;
      ADDR_EVT_DIR: o_reg_rdata = dir_rd;
      ADDR_COMP_CTRL: o_reg_rdata = comp_ctrl;
      default: o_reg_rdata = RST_ZERO;
    endcase
  end

  // Assertions
  chk_pin_source: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_event_pin |-> $past(|(live & evt_route[5:0])))
    else $error("event pin high with no routed live event");
  chk_t_done_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    t_done && !soft_rst |=> t_rdy)
    else $error("temperature done event not raised");
  chk_pa_done_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pa_done && !soft_rst |=> press_alt_done_event)
    else $error("pressure done event not raised");
  chk_pa_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clr_pa && !pa_done |=> !press_alt_done_event)
    else $error("pressure done event not cleared");
  chk_t_read_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_cmd_valid && i_cmd == PTIRQ_CMD_READ_T && !pa_done
    |=> press_alt_done_event == $past(press_alt_done_event))
    else $error("temperature read disturbed pressure event");
  chk_win_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(live[BIT_TEMP_OUTSIDE_EVENT])
    |-> $past(i_temp_meas.valid && evt_en[BIT_T_RDY]))
    else $error("window event without done event");
  chk_t_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clr_t && !t_done |=> !t_rdy)
    else $error("temperature done event not cleared");
  chk_p_read_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_cmd_valid && i_cmd == PTIRQ_CMD_READ_P && !t_done
    |=> t_rdy == $past(t_rdy))
    else $error("pressure read disturbed temperature event");
  chk_flag_mirror: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    flags[BIT_T_RDY] == t_rdy && flags[BIT_PRESS_ALT_DONE_EVENT] == press_alt_done_event)
    else $error("ready flag differs from done event");
  chk_pin_blocked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(|(live & evt_route[5:0])) |=> !o_event_pin)
    else $error("event pin high while all routed events low");
  chk_press_alt_outside_event_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(live[BIT_PRESS_ALT_OUTSIDE_EVENT])
    |-> $past(i_pa_meas.valid && evt_en[BIT_PRESS_ALT_DONE_EVENT]))
    else $error("pressure window event without done event");
  chk_hold_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    t_rdy && !i_cmd_valid |=> t_rdy)
    else $error("done event dropped without a clearing command");
  chk_soft_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    soft_rst |=> flags == 6'h00 && dir == 4'h0 && !t_rdy)
    else $error("soft reset left events set");
  chk_dir_above: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_temp_meas.valid && !soft_rst && t_above
    |=> dir[DIR_TEMP_OUTSIDE_EVENT])
    else $error("window side bit wrong");
endmodule

// *** verification/ptirq_host.sv ***
// Host-side model: register accesses and command pulses
`timescale 1ns/1ps
module ptirq_host
  import ptirq_pkg::*;
(
  // Clock and read data
  input wire logic i_clk,
  input wire logic [7:0] i_reg_rdata,
  // Requests towards the device
  output logic o_reg_en,
  output ptirq_reg_req_s o_reg_req,
  output logic o_cmd_valid,
  output ptirq_cmd_e o_cmd
);
  initial
  begin
    o_reg_en = 1'b0;
    o_reg_req = '0;
    o_cmd_valid = 1'b0;
    o_cmd = PTIRQ_CMD_CONVERT;
  end

  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk);
    #10;
    o_reg_en = 1'b1;
    o_reg_req = '{wr: w, addr: a, wdata: d};
    #1;
    q = i_reg_rdata;
    @(posedge i_clk);
    #10;
    o_reg_en = 1'b0;
    // Stale write data is inverted so nothing relies on it lingering
    o_reg_req.wdata = ~d;
  endtask

  task automatic cmd(input ptirq_cmd_e c);
    // altitude result not fetched within 5 us of its event
    if (c == PTIRQ_CMD_READ_A)
      repeat (50) @(posedge i_clk);
    @(posedge i_clk);
    #10;
    o_cmd_valid = 1'b1;
    o_cmd = c;
    @(posedge i_clk);
    #10;
    o_cmd_valid = 1'b0;
  endtask
endmodule

// *** verification/test_ptirq_core.sv ***
// Self-checking bench for the event interrupt core
`timescale 1ns/1ps
module test_ptirq_core
  import ptirq_pkg::*;
;
  logic clk, rst_n, reg_en, cmd_valid, busy, pin, comp, alt, md, cp;
  ptirq_reg_req_s req;
  ptirq_cmd_e cmd;
  ptirq_meas_s tm, pm;
  logic [7:0] rdata, q;
  logic [15:0] pl [3];
  logic [7:0] tl [3];
  logic [7:0] pa_init [6] = '{8'hC8, 8'hAF, 8'h00, 8'hA0, 8'h43, 8'h9C};
  logic [5:0] en, rt, fl;
  logic [3:0] dr;
  int pv [2];
  bit hv [2];
  int n_fail, n_tests, seed, r, v;

  ptirq_core u_ptirq_core (.i_clk(clk), .i_rst_n(rst_n), .i_reg_en(reg_en),
    .i_reg_req(req), .o_reg_rdata(rdata), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .i_temp_meas(tm), .i_pa_meas(pm), .i_dev_busy(busy),
    .o_event_pin(pin), .o_compensation_enable(comp),
    .o_channel_altitude_select(alt));
  ptirq_host u_ptirq_host (.i_clk(clk), .i_reg_rdata(rdata),
    .o_reg_en(reg_en), .o_reg_req(req), .o_cmd_valid(cmd_valid), .o_cmd(cmd));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic int lim(input int c, input int i);
    if (c == 0)
      return int'($signed(tl[i]));
    return md ? int'($signed(pl[i])) : int'(pl[i]);
  endfunction

  function automatic logic err();
    logic e;
    e = 1'b0;
    for (int c = 0; c < 2; c++)
      e |= lim(c, 2) > lim(c, 0) || lim(c, 1) > lim(c, 0)
           || lim(c, 2) > lim(c, 1);
    return e;
  endfunction

  function automatic logic [7:0] rexp(input logic [3:0] a);
    int k;
    k = (int'(a) - 2) / 2;
    if (a >= 4'h2 && a <= 4'h7)
      return a[0] ? pl[k][15:8] : pl[k][7:0];
    if (a >= 4'h8 && a <= 4'hA)
      return tl[a - 4'h8];
    case (a)
      ADDR_EVT_EN: return {2'h0, en};
      ADDR_EVT_ROUTE: return {1'b0, md, rt};
      ADDR_EVT_FLAGS: return {err(), ~busy, fl};
      ADDR_EVT_DIR: return {cp, 3'h0, dr & fl[3:0]};
      ADDR_COMP_CTRL: return {cp, 7'h00};
      default: return 8'h00;
    endcase
  endfunction

  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [3:0] a);
    u_ptirq_host.acc(1'b0, a, 8'h00, q);
    // Direction bits only mean something while their event flag is set
    if (a == ADDR_EVT_DIR)
      q = q & {4'h8, fl[3:0]};
    cmp($sformatf("reg %h", a), rexp(a), q);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    int k;
    k = (int'(a) - 2) / 2;
    u_ptirq_host.acc(1'b1, a, d, q);
    if (a >= 4'h2 && a <= 4'h7)
      pl[k] = a[0] ? {d, pl[k][7:0]} : {pl[k][15:8], d};
    if (a >= 4'h8 && a <= 4'hA)
      tl[a - 4'h8] = d;
    if (a == ADDR_EVT_EN)
      en = d[5:0];
    if (a == ADDR_EVT_ROUTE)
      {md, rt} = d[6:0];
    if (a == ADDR_COMP_CTRL)
      cp = d[7];
    rchk(a);
    cmp("ctl out", {6'h0, cp, md}, {6'h0, comp, alt});
  endtask

  task automatic check();
    logic [5:0] live;
    rchk(ADDR_EVT_FLAGS);
    rchk(ADDR_EVT_DIR);
    live = fl & {fl[5:4], fl[5:4], fl[5:4]};
    cmp("pin", {7'h00, |(live & rt)}, {7'h00, pin});
  endtask

  task automatic meas(input int c, input int val);
    logic x;
    int up, mid, lo;
    up = lim(c, 0);
    mid = lim(c, 1);
    lo = lim(c, 2);
    x = hv[c] && ((pv[c] < mid) != (val < mid));
    @(posedge clk);
    #10;
    if (c == 0)
      tm = '{1'b1, val[23:0]};
    else
      pm = '{1'b1, val[23:0]};
    @(posedge clk);
    #10;
    tm.valid = 1'b0;
    pm.valid = 1'b0;
    // crossing uses the previous sample of the same channel
    fl[4 + c] = fl[4 + c] | en[4 + c];
    fl[2 + c] = en[4 + c] & en[2 + c] & x;
    fl[c] = en[4 + c] & en[c] & (val > up || val < lo);
    dr[c] = val > up;
    dr[2 + c] = val >= mid;
    pv[c] = val;
    hv[c] = 1'b1;
    check();
  endtask

  task automatic command(input ptirq_cmd_e c);
    u_ptirq_host.cmd(c);
    case (c)
      PTIRQ_CMD_READ_P, PTIRQ_CMD_READ_A: fl[5] = 1'b0;
      PTIRQ_CMD_READ_T: fl[4] = 1'b0;
      PTIRQ_CMD_SOFT_RST:
      begin
        fl = '0;
        dr = '0;
        hv = '{0, 0};
      end
      default: fl[5:4] = 2'b00;
    endcase
    check();
  endtask

  task automatic print_verdict();
    $display("counts: %0d compared, %0d mismatched", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    seed = 32'h35908A0C;
    {n_fail, n_tests, en, rt, fl, dr, md, cp} = '0;
    cp = 1'b1;
    pl = '{16'h0000, 16'h0000, 16'h0000};
    tl = '{8'h00, 8'h00, 8'h00};
    pv = '{0, 0};
    hv = '{0, 0};
    {rst_n, busy, tm, pm} = '0;
    repeat (5) @(posedge clk);
    #10;
    rst_n = 1'b1;
    for (int a = 0; a < 16; a++)
      rchk(a[3:0]);
    $display("test reset values done");
    wreg(4'h1, 8'hFF);
    wreg(ADDR_EVT_FLAGS, 8'hFF);
    wreg(ADDR_EVT_DIR, 8'hFF);
    wreg(ADDR_T_UP, 8'h14);
    wreg(ADDR_T_MID, 8'h00);
    wreg(ADDR_T_LOW, 8'h30);
    rchk(ADDR_EVT_FLAGS);
    wreg(ADDR_T_LOW, 8'hEC);
    for (int i = 0; i < 6; i++)
      wreg(4'(int'(ADDR_PA_UP_LO) + i), pa_init[i]);
    wreg(ADDR_EVT_EN, 8'h3F);
    wreg(ADDR_EVT_ROUTE, 8'h3F);
    $display("test register setup done");
    meas(0, -30);
    meas(0, 30);
    command(PTIRQ_CMD_READ_T);
    meas(1, 50000);
    meas(1, 30000);
    wreg(ADDR_EVT_ROUTE, 8'h7F);
    meas(1, -30000);
    busy = 1'b1;
    rchk(ADDR_EVT_FLAGS);
    busy = 1'b0;
    $display("test directed events done");
    for (int i = 0; i < 7; i++)
    begin
      meas(0, 25);
      meas(1, 0);
      command(ptirq_cmd_e'(i));
    end
    $display("test command clears done");
    repeat (150)
    begin
      r = $random(seed);
      v = md ? int'($signed(r[31:16])) : int'(r[31:16]);
      case (r[3:0])
        4'h0: wreg(ADDR_EVT_EN, r[15:8]);
        4'h1: wreg(ADDR_EVT_ROUTE, r[23:16]);
        4'h2, 4'h3: command(ptirq_cmd_e'(r[6:4] % 3'h7));
        4'h4: wreg(ADDR_COMP_CTRL, r[15:8]);
        default: meas(int'(r[4]), r[4] ? v : int'($signed(r[15:8])));
      endcase
    end
    $display("test random traffic done");
    print_verdict();
  end
endmodule
